// >>> piamp_consts.vh
// Register map, field positions and reset values of the per-port ACL, mirror and priority bank
`ifndef PIAMP_CONSTS_VH
`define PIAMP_CONSTS_VH

// Register indices within one port page; byte address is four times the index
`define PIAMP_IDX_DATA_BASE 12'h600
`define PIAMP_IDX_BE_MSB 12'h610
`define PIAMP_IDX_BE_LSB 12'h611
`define PIAMP_IDX_ACL_CTL 12'h612
`define PIAMP_IDX_MIRROR 12'h800
`define PIAMP_IDX_PRIO 12'h801

// Internal register select codes
`define PIAMP_SEL_BE_MSB 5'h10
`define PIAMP_SEL_BE_LSB 5'h11
`define PIAMP_SEL_ACL_CTL 5'h12
`define PIAMP_SEL_MIRROR 5'h13
`define PIAMP_SEL_PRIO 5'h14
`define PIAMP_SEL_NONE 5'h1F

// Entry access control fields
`define PIAMP_ACL_IDX_MSB 3
`define PIAMP_ACL_DIR_BIT 4
`define PIAMP_ACL_RDONE_BIT 5
`define PIAMP_ACL_WDONE_BIT 6
`define PIAMP_ACL_CTL_RST 5'h00
`define PIAMP_ACL_DONE_RST 1'b1

// Mirroring fields; writable mask keeps reserved bits at zero
`define PIAMP_MIR_RX_BIT 6
`define PIAMP_MIR_TX_BIT 5
`define PIAMP_MIR_SNIFFER_BIT 1
`define PIAMP_MIR_WMASK 8'h62
`define PIAMP_MIR_RST 8'h00

// Priority fields; bit 5 reserved
`define PIAMP_PRI_HIGH_BIT 7
`define PIAMP_PRI_OR_BIT 6
`define PIAMP_PRI_SRC_MSB 4
`define PIAMP_PRI_WMASK 8'hDF
`define PIAMP_PRI_RST 8'h00

`endif

// >>> piamp_entry_ram.v
// Entry table storage: one 16-byte word per port and entry, byte writes, registered read
`timescale 1ns/1ns
module piamp_entry_ram (
    input wire ref_clk, // Switch clock
    input wire en, // Access strobe
    input wire [6:0] addr, // Port-1 and entry index
    input wire [15:0] byte_we, // Per-byte write enable, bit k writes byte k at wdata bits 8k+7:8k
    input wire [127:0] wdata, // Write data
    output reg [127:0] rdata // Read data, valid the cycle after en
);
    reg [127:0] mem [0:127];
    integer k;

    // No reset on the array; rdata is only captured by the caller after a read
    always @(posedge ref_clk) begin
        if (en) begin
            for (k = 0; k < 16; k = k + 1) begin
                if (byte_we[k]) begin
                    mem[addr][k*8 +: 8] <= wdata[k*8 +: 8];
                end
            end
            rdata <= mem[addr];
        end
    end
endmodule

// >>> piamp_prio_merge.v
// Combines the classified priorities of one port as its priority control selects
`timescale 1ns/1ns
module piamp_prio_merge (
    input wire ref_clk, // Switch clock
    input wire sys_rst, // Asynchronous reset, active high
    input wire sel_high, // Take highest available priority
    input wire sel_or, // OR all available priorities
    input wire [4:0] src_en, // Source enables: 0 ACL, 1 Diffserv, 2 802.1p, 3 VLAN, 4 MAC
    input wire [4:0] src_valid, // Source produced a classification
    input wire [14:0] src_prio, // Three bits per source, source s at 3s+2:3s
    input wire [2:0] dflt_prio, // Used when no enabled source classifies
    output reg [2:0] prio // Resulting priority
);
    reg [4:0] avail;
    reg [2:0] hi_v;
    reg [2:0] or_v;
    reg [2:0] first_v;
    reg found;
    reg [2:0] res;
    integer s;

    always @* begin
        avail = src_en & src_valid;
        hi_v = 3'h0;
        or_v = 3'h0;
        first_v = 3'h0;
        found = 1'b0;
        for (s = 0; s < 5; s = s + 1) begin
            if (avail[s]) begin
                if (src_prio[s*3 +: 3] > hi_v) begin
                    hi_v = src_prio[s*3 +: 3];
                end
                or_v = or_v | src_prio[s*3 +: 3];
                if (!found) begin
                    first_v = src_prio[s*3 +: 3];
                end
                found = 1'b1;
            end
        end
        // Highest wins when software sets both mode bits against advice
        if (!found) begin
            res = dflt_prio;
        end else if (sel_high) begin
            res = hi_v;
        end else if (sel_or) begin
            res = or_v;
        end else begin
            res = first_v;
        end
    end

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prio <= 3'h0;
        end else begin
            prio <= res;
        end
    end
endmodule

// >>> piamp_regs.v
// Per-port ACL entry access, mirroring and priority control registers on classic Wishbone
//
// Notes on behaviour
// - Control byte: index bits 3:0, direction bit 4
// - Bit 6 reads write done, resets one
// - Bit 5 reads read done, resets one
// - Receive sniff marks received packets monitored
// - Transmit sniff marks transmitted packets monitored
// - Sniffer bit makes port transmit monitored packets
// - Mirror reserved bits read zero
// - Bit 7 highest, bit 6 OR, bit 5 zero
// - Bit 4 enables MAC address classification
// - Bit 3 enables VLAN classification
// - Bit 2 enables 802.1p classification
// - Bit 1 enables Diffserv classification
// - Bit 0 enables ACL action classification
// - Low byte-enable write starts selected-byte transfer
`timescale 1ns/1ns
`include "piamp_consts.vh"
module piamp_regs (
    input wire ref_clk, // Switch clock, 50 MHz
    input wire sys_rst, // Asynchronous reset, active high
    input wire wb_cyc_i, // Wishbone cycle
    input wire wb_stb_i, // Wishbone strobe
    input wire wb_we_i, // Wishbone write
    input wire [17:0] wb_adr_i, // Byte address, bits 17:2 are the register index
    input wire [3:0] wb_sel_i, // Byte selects, lane 0 carries the register
    input wire [31:0] wb_dat_i, // Write data
    output wire [31:0] wb_dat_o, // Read data
    output wire wb_ack_o, // Acknowledge, one cycle
    input wire [6:0] rx_pkt_i, // Packet received on port n+1, one-cycle pulse
    input wire [6:0] tx_pkt_i, // Packet transmitted on port n+1, one-cycle pulse
    output wire [6:0] rx_mon_o, // Received packet marked monitored
    output wire [6:0] tx_mon_o, // Transmitted packet marked monitored
    output wire [6:0] rx_sniff_o, // Receive sniff enabled per port
    output wire [6:0] tx_sniff_o, // Transmit sniff enabled per port
    output wire [6:0] sniffer_port_o, // Port transmits monitored packets
    output wire [6:0] prio_high_o, // Highest-priority mode per port
    output wire [6:0] prio_or_o, // OR-priority mode per port
    output wire [34:0] prio_src_en_o, // Five source enables per port
    input wire [34:0] cls_valid_i, // Five classifier valids per port
    input wire [104:0] cls_prio_i, // Five 3-bit classified priorities per port
    input wire [20:0] dflt_prio_i, // Default priority per port
    output wire [20:0] prio_o // Combined priority per port
);
    localparam S_IDLE = 1'b0;
    localparam S_CAP = 1'b1;

    reg ack_q;
    reg [7:0] rdat_q;
    reg [7:0] data_q [0:111];
    reg [15:0] be_q [0:6];
    reg [4:0] ctl_q [0:6];
    reg [7:0] mir_q [0:6];
    reg [7:0] pri_q [0:6];
    reg [6:0] wdone_q;
    reg [6:0] rdone_q;
    reg [6:0] pend_q;
    reg [6:0] rx_mon_q;
    reg [6:0] tx_mon_q;
    reg state_q;
    reg [2:0] cur_q;
    reg cur_wr_q;
    reg [15:0] cur_be_q;
    reg [15:0] cur_be_d;
    reg ram_en_d;
    reg [6:0] ram_addr_d;
    reg [15:0] ram_we_d;
    reg [127:0] ram_wdata_d;
    reg [7:0] rdat_d;
    reg [2:0] pick_d;
    reg pick_any_d;
    wire [127:0] ram_rdata;
    wire req;
    wire wr_req;
    wire [3:0] req_port;
    wire [4:0] req_sel;
    wire [2:0] req_pi;
    wire start;
    integer i;
    integer k;
    integer pick_i;
    integer be_k;
    integer wd_k;
    integer flag_i;
    integer mon_i;

    // Maps a register index to a select code; port pages 1 to 7 only
    function [4:0] piamp_decode;
        input [15:0] idx;
        begin
            if (idx[15:12] == 4'h0 || idx[15:12] > 4'h7) begin
                piamp_decode = `PIAMP_SEL_NONE;
            end else if ({4'h0, idx[11:4]} == (`PIAMP_IDX_DATA_BASE >> 4)) begin
                piamp_decode = {1'b0, idx[3:0]};
            end else if (idx[11:0] == `PIAMP_IDX_BE_MSB) begin
                piamp_decode = `PIAMP_SEL_BE_MSB;
            end else if (idx[11:0] == `PIAMP_IDX_BE_LSB) begin
                piamp_decode = `PIAMP_SEL_BE_LSB;
            end else if (idx[11:0] == `PIAMP_IDX_ACL_CTL) begin
                piamp_decode = `PIAMP_SEL_ACL_CTL;
            end else if (idx[11:0] == `PIAMP_IDX_MIRROR) begin
                piamp_decode = `PIAMP_SEL_MIRROR;
            end else if (idx[11:0] == `PIAMP_IDX_PRIO) begin
                piamp_decode = `PIAMP_SEL_PRIO;
            end else begin
                piamp_decode = `PIAMP_SEL_NONE;
            end
        end
    endfunction

    // Requests are taken once, in the cycle before ack rises
    assign req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr_req = req & wb_we_i & wb_sel_i[0];
    assign req_port = wb_adr_i[17:14];
    assign req_sel = piamp_decode(wb_adr_i[17:2]);
    assign req_pi = req_port[2:0] - 3'h1;
    assign start = wr_req & (req_sel == `PIAMP_SEL_BE_LSB);

    always @* begin
        rdat_d = 8'h00;
        if (req_sel < 5'h10) begin
            rdat_d = data_q[{req_pi, 4'h0} + {3'h0, req_sel[3:0]}];
        end else begin
            case (req_sel)
                `PIAMP_SEL_BE_MSB: rdat_d = be_q[req_pi][15:8];
                `PIAMP_SEL_BE_LSB: rdat_d = be_q[req_pi][7:0];
                `PIAMP_SEL_ACL_CTL: rdat_d = {1'b0, wdone_q[req_pi], rdone_q[req_pi],
                    ctl_q[req_pi]};
                `PIAMP_SEL_MIRROR: rdat_d = mir_q[req_pi];
                `PIAMP_SEL_PRIO: rdat_d = pri_q[req_pi];
                default: rdat_d = 8'h00;
            endcase
        end
    end

    // Unmapped addresses are acknowledged, read zero and ignore writes
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
            rdat_q <= 8'h00;
        end else begin
            ack_q <= req;
            if (req && !wb_we_i) begin
                rdat_q <= rdat_d;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = {24'h000000, rdat_q};

    // Lowest pending port is served first; ports are served one at a time
    always @* begin
        pick_d = 3'h0;
        pick_any_d = 1'b0;
        for (pick_i = 6; pick_i >= 0; pick_i = pick_i - 1) begin
            if (pend_q[pick_i]) begin
                pick_d = pick_i[2:0];
                pick_any_d = 1'b1;
            end
        end
    end

    // Byte enable bit 15 selects data byte 0, bit 0 selects byte 15
    always @* begin
        cur_be_d = 16'h0000;
        for (be_k = 0; be_k < 16; be_k = be_k + 1) begin
            cur_be_d[be_k] = be_q[pick_d][15 - be_k];
        end
    end

    always @* begin
        ram_en_d = (state_q == S_IDLE) & pick_any_d;
        ram_addr_d = {pick_d, ctl_q[pick_d][`PIAMP_ACL_IDX_MSB:0]};
        ram_we_d = ctl_q[pick_d][`PIAMP_ACL_DIR_BIT] ? cur_be_d : 16'h0000;
        ram_wdata_d = 128'h0;
        for (wd_k = 0; wd_k < 16; wd_k = wd_k + 1) begin
            ram_wdata_d[wd_k*8 +: 8] = data_q[{pick_d, 4'h0} + wd_k[6:0]];
        end
    end

    piamp_entry_ram u_ram (
        .ref_clk(ref_clk),
        .en(ram_en_d),
        .addr(ram_addr_d),
        .byte_we(ram_we_d),
        .wdata(ram_wdata_d),
        .rdata(ram_rdata)
    );

    // Entry access sequencer: issue in idle, finish one cycle later
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= S_IDLE;
            cur_q <= 3'h0;
            cur_wr_q <= 1'b0;
            cur_be_q <= 16'h0000;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (pick_any_d) begin
                        cur_q <= pick_d;
                        cur_wr_q <= ctl_q[pick_d][`PIAMP_ACL_DIR_BIT];
                        cur_be_q <= cur_be_d;
                        state_q <= S_CAP;
                    end
                end
                S_CAP: state_q <= S_IDLE;
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // Pending requests and completion flags
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pend_q <= 7'h00;
            wdone_q <= {7{`PIAMP_ACL_DONE_RST}};
            rdone_q <= {7{`PIAMP_ACL_DONE_RST}};
        end else begin
            for (flag_i = 0; flag_i < 7; flag_i = flag_i + 1) begin
                if (start && req_pi == flag_i[2:0]) begin
                    pend_q[flag_i] <= 1'b1;
                    if (ctl_q[flag_i][`PIAMP_ACL_DIR_BIT]) begin
                        wdone_q[flag_i] <= 1'b0;
                    end else begin
                        rdone_q[flag_i] <= 1'b0;
                    end
                end else if (ram_en_d && pick_d == flag_i[2:0]) begin
                    pend_q[flag_i] <= 1'b0;
                end
                // Completion set wins over a start in the same cycle
                if (state_q == S_CAP && cur_q == flag_i[2:0]) begin
                    if (cur_wr_q) begin
                        wdone_q[flag_i] <= 1'b1;
                    end else begin
                        rdone_q[flag_i] <= 1'b1;
                    end
                end
            end
        end
    end

    // Software-visible registers; read capture overrides a bus write to the same byte
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (i = 0; i < 112; i = i + 1) begin
                data_q[i] <= 8'h00;
            end
            for (i = 0; i < 7; i = i + 1) begin
                be_q[i] <= 16'h0000;
                ctl_q[i] <= `PIAMP_ACL_CTL_RST;
                mir_q[i] <= `PIAMP_MIR_RST;
                pri_q[i] <= `PIAMP_PRI_RST;
            end
        end else begin
            if (wr_req) begin
                if (req_sel < 5'h10) begin
                    data_q[{req_pi, 4'h0} + {3'h0, req_sel[3:0]}] <= wb_dat_i[7:0];
                end
                case (req_sel)
                    `PIAMP_SEL_BE_MSB: be_q[req_pi][15:8] <= wb_dat_i[7:0];
                    `PIAMP_SEL_BE_LSB: be_q[req_pi][7:0] <= wb_dat_i[7:0];
                    `PIAMP_SEL_ACL_CTL: ctl_q[req_pi] <= wb_dat_i[4:0];
                    `PIAMP_SEL_MIRROR: mir_q[req_pi] <= wb_dat_i[7:0] & `PIAMP_MIR_WMASK;
                    `PIAMP_SEL_PRIO: pri_q[req_pi] <= wb_dat_i[7:0] & `PIAMP_PRI_WMASK;
                    default: ;
                endcase
            end
            if (state_q == S_CAP && !cur_wr_q) begin
                for (k = 0; k < 16; k = k + 1) begin
                    if (cur_be_q[k]) begin
                        data_q[{cur_q, 4'h0} + k[6:0]] <= ram_rdata[k*8 +: 8];
                    end
                end
            end
        end
    end

    // Per-packet monitor marking
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_mon_q <= 7'h00;
            tx_mon_q <= 7'h00;
        end else begin
            for (mon_i = 0; mon_i < 7; mon_i = mon_i + 1) begin
                rx_mon_q[mon_i] <= rx_pkt_i[mon_i] & mir_q[mon_i][`PIAMP_MIR_RX_BIT];
                tx_mon_q[mon_i] <= tx_pkt_i[mon_i] & mir_q[mon_i][`PIAMP_MIR_TX_BIT];
            end
        end
    end

    assign rx_mon_o = rx_mon_q;
    assign tx_mon_o = tx_mon_q;

    genvar g;
    generate
        for (g = 0; g < 7; g = g + 1) begin : g_port
            assign rx_sniff_o[g] = mir_q[g][`PIAMP_MIR_RX_BIT];
            assign tx_sniff_o[g] = mir_q[g][`PIAMP_MIR_TX_BIT];
            assign sniffer_port_o[g] = mir_q[g][`PIAMP_MIR_SNIFFER_BIT];
            assign prio_high_o[g] = pri_q[g][`PIAMP_PRI_HIGH_BIT];
            assign prio_or_o[g] = pri_q[g][`PIAMP_PRI_OR_BIT];
            // Bit 4 MAC, 3 VLAN, 2 802.1p, 1 Diffserv, 0 ACL
            assign prio_src_en_o[g*5 +: 5] = pri_q[g][`PIAMP_PRI_SRC_MSB:0];

            piamp_prio_merge u_merge (
                .ref_clk(ref_clk),
                .sys_rst(sys_rst),
                .sel_high(pri_q[g][`PIAMP_PRI_HIGH_BIT]),
                .sel_or(pri_q[g][`PIAMP_PRI_OR_BIT]),
                .src_en(pri_q[g][`PIAMP_PRI_SRC_MSB:0]),
                .src_valid(cls_valid_i[g*5 +: 5]),
                .src_prio(cls_prio_i[g*15 +: 15]),
                .dflt_prio(dflt_prio_i[g*3 +: 3]),
                .prio(prio_o[g*3 +: 3])
            );
        end
    endgenerate
endmodule

// >>> piamp_regs_checker.sv
// Concurrent checks on the ports of the per-port register bank
`timescale 1ns/1ns
module piamp_regs_checker (
    input wire ref_clk, // Clock
    input wire sys_rst, // Reset
    input wire wb_cyc_i, // Cycle
    input wire wb_stb_i, // Strobe
    input wire wb_we_i, // Write
    input wire [17:0] wb_adr_i, // Address
    input wire [3:0] wb_sel_i, // Selects
    input wire [31:0] wb_dat_i, // Write data
    input wire [31:0] wb_dat_o, // Read data
    input wire wb_ack_o, // Ack
    input wire [6:0] rx_pkt_i, // Rx pulses
    input wire [6:0] tx_pkt_i, // Tx pulses
    input wire [6:0] rx_mon_o, // Rx monitored
    input wire [6:0] tx_mon_o, // Tx monitored
    input wire [6:0] rx_sniff_o, // Rx sniff
    input wire [6:0] tx_sniff_o, // Tx sniff
    input wire [6:0] sniffer_port_o, // Sniffer role
    input wire [6:0] prio_high_o, // Highest mode
    input wire [6:0] prio_or_o, // OR mode
    input wire [34:0] prio_src_en_o, // Source enables
    input wire [34:0] cls_valid_i, // Source valids
    input wire [104:0] cls_prio_i, // Source priorities
    input wire [20:0] prio_o // Result
);
    logic [4:0] av;
    logic [2:0] or_v;
    logic [2:0] max_v;
    wire tk = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr1 = tk & wb_we_i & wb_sel_i[0];
    // Read data is judged while the master still holds the address
    wire rdk = wb_ack_o & wb_cyc_i & ~wb_we_i;
    assign av = prio_src_en_o[4:0] & cls_valid_i[4:0];
    always @* begin
        or_v = 3'h0;
        max_v = 3'h0;
        for (int s = 0; s < 5; s++) begin
            if (av[s]) begin
                or_v = or_v | cls_prio_i[3*s+:3];
                if (cls_prio_i[3*s+:3] > max_v) max_v = cls_prio_i[3*s+:3];
            end
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    property p_rx_mon; 1'b1 |=> rx_mon_o == $past(rx_pkt_i & rx_sniff_o); endproperty
    a_rx_mon: assert property (p_rx_mon) else $error("rx monitor mark wrong");
    property p_tx_mon; 1'b1 |=> tx_mon_o == $past(tx_pkt_i & tx_sniff_o); endproperty
    a_tx_mon: assert property (p_tx_mon) else $error("tx monitor mark wrong");
    property p_mir_wr;
        wr1 && wb_adr_i == 18'h06000 |=> sniffer_port_o[0] == $past(wb_dat_i[1])
            && rx_sniff_o[0] == $past(wb_dat_i[6]) && tx_sniff_o[0] == $past(wb_dat_i[5]);
    endproperty
    a_mir_wr: assert property (p_mir_wr) else $error("mirror write not applied");
    property p_mir_rsv; rdk && wb_adr_i == 18'h06000 |-> (wb_dat_o & 32'hFFFFFF9D) == 32'h0; endproperty
    a_mir_rsv: assert property (p_mir_rsv) else $error("mirror reserved bit set");
    property p_pri_rsv; rdk && wb_adr_i == 18'h06004 |-> (wb_dat_o & 32'hFFFFFF20) == 32'h0; endproperty
    a_pri_rsv: assert property (p_pri_rsv) else $error("priority reserved bit set");
    property p_pri_wr;
        wr1 && wb_adr_i == 18'h06004 |=> prio_src_en_o[4:0] == $past(wb_dat_i[4:0])
            && prio_high_o[0] == $past(wb_dat_i[7]) && prio_or_o[0] == $past(wb_dat_i[6]);
    endproperty
    a_pri_wr: assert property (p_pri_wr) else $error("priority write not applied");
    property p_pri_max; prio_high_o[0] && (|av) |=> prio_o[2:0] == $past(max_v); endproperty
    a_pri_max: assert property (p_pri_max) else $error("highest priority wrong");
    property p_pri_or;
        prio_or_o[0] && !prio_high_o[0] && (|av) |=> prio_o[2:0] == $past(or_v);
    endproperty
    a_pri_or: assert property (p_pri_or) else $error("OR priority wrong");
    property p_ctl_rd; rdk && wb_adr_i == 18'h05848 |-> wb_dat_o[31:7] == 25'h0; endproperty
    a_ctl_rd: assert property (p_ctl_rd) else $error("control byte upper bits set");
    c_mir: cover property (wr1 && wb_adr_i == 18'h06000);
    c_ctl: cover property (rdk && wb_adr_i == 18'h05848 && wb_dat_o[4]);
    c_or: cover property (prio_or_o[0] && !prio_high_o[0] && (|av));
endmodule

bind piamp_regs piamp_regs_checker piamp_regs_checker_inst (.ref_clk, .sys_rst, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_pkt_i,
    .tx_pkt_i, .rx_mon_o, .tx_mon_o, .rx_sniff_o, .tx_sniff_o, .sniffer_port_o, .prio_high_o,
    .prio_or_o, .prio_src_en_o, .cls_valid_i, .cls_prio_i, .prio_o);

// >>> piamp_regs_tb.sv
// Self-checking bench for the per-port ACL, mirror and priority registers
`timescale 1ns/1ns
module piamp_regs_tb;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [17:0] wb_adr_i = 18'h00000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [6:0] rx_pkt_i = 7'h00;
    logic [6:0] tx_pkt_i = 7'h00;
    logic [34:0] cls_valid_i = 35'h7FFFFFFFF;
    // Port 1 sources 0..4 classify as 1, 2, 4, 3, 5
    logic [104:0] cls_prio_i = 105'h05711;
    logic [20:0] dflt_prio_i = 21'h000006;
    wire [31:0] wb_dat_o;
    wire wb_ack_o;
    wire [6:0] rx_mon_o, tx_mon_o, rx_sniff_o, tx_sniff_o, sniffer_port_o, prio_high_o, prio_or_o;
    wire [34:0] prio_src_en_o;
    wire [20:0] prio_o;
    int n_fail = 0;
    int compares = 0;
    localparam logic [17:0] CTL = 18'h05848, MIR = 18'h06000, PRI = 18'h06004;
    localparam logic [17:0] D0 = 18'h05800, D1 = 18'h05804, D15 = 18'h0583C;
    localparam logic [17:0] BEM = 18'h05840, BEL = 18'h05844;

    always #10 ref_clk = ~ref_clk;

    piamp_regs piamp_regs_inst (.ref_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_pkt_i, .tx_pkt_i, .rx_mon_o, .tx_mon_o,
        .rx_sniff_o, .tx_sniff_o, .sniffer_port_o, .prio_high_o, .prio_or_o, .prio_src_en_o,
        .cls_valid_i, .cls_prio_i, .dflt_prio_i, .prio_o);

    task close_out;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Classic cycle: hold everything until ack is sampled, then release
    task xfer(input logic [17:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h000000, d};
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o[7:0];
        if (n >= 50) chk({31'h0, wb_ack_o}, 32'h1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task wr(input logic [17:0] a, input logic [7:0] d);
        logic [7:0] q;
        xfer(a, 1'b1, d, q);
    endtask

    task rd_chk(input logic [17:0] a, input logic [7:0] e);
        logic [7:0] q;
        xfer(a, 1'b0, 8'h00, q);
        chk({24'h0, q}, {24'h0, e});
    endtask

    // Polling bounded so a stuck flag ends as a mismatch, not a hang
    task poll(input int b);
        logic [7:0] q;
        int n;
        n = 0;
        do begin
            xfer(CTL, 1'b0, 8'h00, q);
            n++;
        end while (q[b] !== 1'b1 && n < 20);
        chk({31'h0, q[b]}, 32'h1);
    endtask

    // The flag returns two cycles after the taking edge, sooner than any bus read,
    // so the cleared state is caught inside the bank one cycle after the taking edge
    task start_op(input logic w);
        logic f;
        fork
            wr(BEL, 8'h01);
            begin
                @(posedge ref_clk iff wb_ack_o === 1'b1);
                #1;
                f = w ? piamp_regs_inst.wdone_q[0] : piamp_regs_inst.rdone_q[0];
                chk({31'h0, f}, 32'h0);
            end
        join
    endtask

    task mon_pulse(input logic [6:0] erx, input logic [6:0] etx);
        @(posedge ref_clk);
        rx_pkt_i <= 7'h7F;
        tx_pkt_i <= 7'h7F;
        @(posedge ref_clk);
        rx_pkt_i <= 7'h00;
        tx_pkt_i <= 7'h00;
        #1;
        chk({25'h0, rx_mon_o}, {25'h0, erx});
        chk({25'h0, tx_mon_o}, {25'h0, etx});
    endtask

    task t_reset_ctl;
        rd_chk(CTL, 8'h60);
        rd_chk(MIR, 8'h00);
        rd_chk(PRI, 8'h00);
        wr(18'h00000, 8'hFF);
        rd_chk(18'h00000, 8'h00);
        wr(CTL, 8'hFF);
        rd_chk(CTL, 8'h7F);
        wr(CTL, 8'h05);
        rd_chk(CTL, 8'h65);
        rd_chk(18'h09848, 8'h60);
    endtask

    // The global mirror register lies outside this bank; only port bits are set here
    task t_mirror;
        wr(MIR, 8'hFF);
        rd_chk(MIR, 8'h62);
        chk({25'h0, sniffer_port_o}, 32'h01);
        mon_pulse(7'h01, 7'h01);
        wr(MIR, 8'h40);
        chk({25'h0, sniffer_port_o}, 32'h00);
        mon_pulse(7'h01, 7'h00);
    endtask

    task t_prio;
        logic [2:0] exp_p [5] = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h5};
        for (int s = 0; s < 5; s++) begin
            wr(PRI, 8'h01 << s);
            @(posedge ref_clk);
            #1;
            chk({27'h0, prio_src_en_o[4:0]}, 32'h1 << s);
            chk({29'h0, prio_o[2:0]}, {29'h0, exp_p[s]});
        end
        wr(PRI, 8'h00);
        @(posedge ref_clk);
        #1;
        chk({29'h0, prio_o[2:0]}, 32'h6);
        wr(PRI, 8'hFF);
        rd_chk(PRI, 8'hDF);
        @(posedge ref_clk);
        #1;
        chk({29'h0, prio_o[2:0]}, 32'h5);
        wr(PRI, 8'h5F);
        @(posedge ref_clk);
        #1;
        chk({29'h0, prio_o[2:0]}, 32'h7);
    endtask

    task t_entry;
        wr(D0, 8'hA5);
        wr(D15, 8'h3C);
        wr(D1, 8'h77);
        wr(BEM, 8'h80);
        wr(CTL, 8'h13);
        start_op(1'b1);
        rd_chk(CTL, 8'h73);
        poll(6);
        wr(D0, 8'h00);
        wr(D15, 8'h00);
        wr(D1, 8'h5A);
        wr(CTL, 8'h03);
        start_op(1'b0);
        rd_chk(CTL, 8'h63);
        poll(5);
        rd_chk(D0, 8'hA5);
        rd_chk(D15, 8'h3C);
        rd_chk(D1, 8'h5A);
    endtask

    initial begin
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_reset_ctl();
        t_mirror();
        t_prio();
        t_entry();
        close_out();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        close_out();
    end
endmodule
